// *** src_pkg.sv ***
/*
 * Package for the reset and bus-clock controller: timing counts, vectors,
 * reset-cause bit positions and register offsets.
 * Assumes a 100 MHz osc_clock_x4 domain clock.
 */
package src_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned SRC_CLK_MHZ = 100;
	localparam int unsigned SRC_POR_CYCLES = 4096;
	localparam int unsigned SRC_STOP_LONG_CYCLES = 4096;
	localparam int unsigned SRC_STOP_SHORT_CYCLES = 32;
	localparam int unsigned SRC_PIN_DRIVE_CYCLES = 32;
	localparam int unsigned SRC_INTERNAL_RESET_TAIL_CYCLES = 32;
	localparam int unsigned SRC_RESET_LOW_NS = 100;
	localparam int unsigned SRC_RESET_LOW_CYCLES =
		(SRC_RESET_LOW_NS * SRC_CLK_MHZ + 999) / 1000;
	localparam int unsigned SRC_PRESCALE_STAGES = 12;

	// ---------------------------------------------------------------
	// Vectors
	// ---------------------------------------------------------------
	localparam logic [15:0] SRC_VEC_NORMAL = 16'hfffe;
	localparam logic [15:0] SRC_VEC_MONITOR = 16'hfefe;

	// ---------------------------------------------------------------
	// Reset cause bit positions
	// ---------------------------------------------------------------
	localparam int unsigned SRC_CAUSE_W = 6;
	localparam int unsigned SRC_CAUSE_POR = 0;
	localparam int unsigned SRC_CAUSE_PIN = 1;
	localparam int unsigned SRC_CAUSE_WDOG = 2;
	localparam int unsigned SRC_CAUSE_LVD = 3;
	localparam int unsigned SRC_CAUSE_ILOP = 4;
	localparam int unsigned SRC_CAUSE_ILAD = 5;

	// ---------------------------------------------------------------
	// Register offsets and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] SRC_REG_CAUSE = 4'h0;
	localparam logic [3:0] SRC_REG_CONFIG_REGISTER_TWO = 4'h1;
	localparam logic [3:0] SRC_REG_CONFIG1 = 4'h2;
	localparam logic [3:0] SRC_REG_IRQ_STATUS = 4'h3;
	localparam logic [3:0] SRC_REG_IRQ_MASK = 4'h4;
	localparam logic [3:0] SRC_REG_CONTROL = 4'h5;
	localparam logic [3:0] SRC_REG_IRQ_PEND0 = 4'h6;
	localparam int unsigned SRC_CFG2_RESET_PIN_ENABLE = 0;
	localparam int unsigned SRC_CFG2_IRQEN = 1;
	localparam int unsigned SRC_CFG1_SHORT_STOP_RECOVERY = 0;
	localparam int unsigned SRC_CTL_STOP = 0;
	localparam int unsigned SRC_CTL_WAIT = 1;
	localparam int unsigned SRC_CTL_MONITOR = 2;
	localparam logic [7:0] SRC_CONFIG_RESET = 8'h00;
	localparam int unsigned SRC_IRQ_SOURCES = 24;

	// Events raised to the status register.
	localparam int unsigned SRC_EV_RESET_DONE = 0;
	localparam int unsigned SRC_EV_STOP_DONE = 1;
	localparam int unsigned SRC_EV_PIN_RESET = 2;

	typedef enum logic [2:0] {
		SRC_ST_POR_WAIT,
		SRC_ST_PIN_DRIVE,
		SRC_ST_INTERNAL_RESET_TAIL,
		SRC_ST_RUN,
		SRC_ST_WAIT,
		SRC_ST_STOP,
		SRC_ST_STOP_RECOVER,
		SRC_ST_EXT_HOLD
	} src_state_t;

endpackage

// *** src_prescaler.sv ***
/*
 * Prescaler counter: 12 counting stages and a 13th stage that ticks the
 * watchdog and restarts the count.
 * Assumes clk_in is osc_clock_x4 and that clear comes from the same domain.
 */
`timescale 1ns/1ps
module src_prescaler
	import src_pkg::*;
#(
	parameter int unsigned STAGES = SRC_PRESCALE_STAGES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic clear_in,
	output logic [STAGES-1:0] count_out,
	output logic wdog_tick_out
);

	typedef struct packed {
		logic [STAGES-1:0] count;
		logic tick;
	} src_pre_state_t;

	src_pre_state_t state;
	src_pre_state_t next_state;

	// ---------------------------------------------------------------
	// Counting
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		if (clear_in) begin
			next_state.count = '0;
		end else begin
			next_state.count = state.count + 1'b1;
			next_state.tick = &state.count;
		end
	end

	// The count advances on the falling edge of the clock.
	always_ff @(negedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
		end else if (clk_en_in) begin
			state <= next_state;
		end
	end

	assign count_out = state.count;
	assign wdog_tick_out = state.tick;

endmodule // src_prescaler

// *** src_reset_clock.sv ***
/*
 * Reset and bus-clock controller: bus clock enables, power-on and stop
 * delays, reset sources, internal reset, reset pin handling and cause flags.
 * Assumes clk_in is osc_clock_x4 and all source inputs except the pin are
 * synchronous to it.
 */
// Function
// - Bus clock is osc_clock_x4 divided by four
// - Halve to x2, then halve again
// - Hold clocks 4096 cycles after power-on
// - Stop exit waits 4096 or 32 cycles
// - Wait stops processor clocks, peripherals run
// - Six reset sources all assert internal reset
// - Vector FFFE, or FEFE in monitor mode
// - Internal sources reset config, control and pending requests; pin reset only control and pending
// - Internal resets clear prescaler, pin does not
// - Each reset sets its cause flag
// - Pulled-up asynchronous pin halts processing
// - Pin cause needs minimum low time
// - Pin resets only with reset_pin_enable
// - Pins default to port bits after all resets except a pin reset
// - Accept up to 24 interrupt requests
// - Drive pin 32 cycles, hold 32 more
// - Prescaler 12 stages, falling edge
// - short_stop_recovery selects 32-cycle delay
`timescale 1ns/1ps
module src_reset_clock
	import src_pkg::*;
#(
	parameter int unsigned POR_CYCLES = SRC_POR_CYCLES,
	parameter int unsigned STOP_LONG_CYCLES = SRC_STOP_LONG_CYCLES,
	parameter int unsigned IRQ_SOURCES = SRC_IRQ_SOURCES
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic power_on_pulse_in,
	input wire logic wdog_timeout_in,
	input wire logic low_voltage_in,
	input wire logic illegal_opcode_in,
	input wire logic illegal_address_in,
	input wire logic reset_pin_in,
	input wire logic [IRQ_SOURCES-1:0] irq_req_in,
	input wire logic wake_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic reset_pin_out,
	output logic reset_pin_oe_out,
	output logic reset_pin_pullup_out,
	output logic port_a_bit3_mode_out,
	output logic port_a_bit2_mode_out,
	output logic internal_reset_out,
	output logic osc_clock_x2_out,
	output logic bus_clk_en_out,
	output logic cpu_clk_en_out,
	output logic periph_clk_en_out,
	output logic [15:0] reset_vector_out,
	output logic [IRQ_SOURCES-1:0] irq_pending_out,
	output logic [SRC_PRESCALE_STAGES-1:0] prescale_out,
	output logic wdog_tick_out,
	output logic irq_out
);

	localparam int unsigned CW = 13;

	typedef struct packed {
		src_state_t fsm;
		logic [CW-1:0] cnt;
		logic [1:0] div;
		logic pin_meta;
		logic pin_sync;
		logic [CW-1:0] low_cnt;
		logic pin_long;
		logic [SRC_CAUSE_W-1:0] cause;
		logic [7:0] config_register_two;
		logic [7:0] config1;
		logic [7:0] control;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [IRQ_SOURCES-1:0] irq_pend;
		logic [7:0] rdata;
		logic pre_clear;
	} src_state_s_t;

	src_state_s_t state;
	src_state_s_t next_state;

	logic pin_low;
	logic int_src;
	logic [SRC_CAUSE_W-1:0] src_vec;
	logic [2:0] ev;

	// ---------------------------------------------------------------
	// Source decoding
	// ---------------------------------------------------------------
	// The block's own pin drive must not read back as an outside pin reset.
	assign pin_low = ~state.pin_sync & state.config_register_two[SRC_CFG2_RESET_PIN_ENABLE]
		& (state.fsm != SRC_ST_PIN_DRIVE);
	assign int_src = power_on_pulse_in | wdog_timeout_in | low_voltage_in
		| illegal_opcode_in | illegal_address_in;

	always_comb begin
		src_vec = '0;
		src_vec[SRC_CAUSE_POR] = power_on_pulse_in;
		src_vec[SRC_CAUSE_WDOG] = wdog_timeout_in;
		src_vec[SRC_CAUSE_LVD] = low_voltage_in;
		src_vec[SRC_CAUSE_ILOP] = illegal_opcode_in;
		src_vec[SRC_CAUSE_ILAD] = illegal_address_in;
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		ev = '0;
		next_state.pre_clear = 1'b0;
		next_state.rdata = '0;
		next_state.pin_meta = reset_pin_in;
		next_state.pin_sync = state.pin_meta;
		next_state.div = state.div + 2'd1;
		if (pin_low) begin
			next_state.low_cnt = (state.low_cnt == CW'(SRC_RESET_LOW_CYCLES)) ?
				state.low_cnt : state.low_cnt + 1'b1;
		end else begin
			next_state.low_cnt = '0;
		end
		next_state.pin_long = pin_low &&
			(state.low_cnt + 1'b1 >= CW'(SRC_RESET_LOW_CYCLES));
		next_state.cnt = state.cnt + 1'b1;

		case (state.fsm)
			SRC_ST_POR_WAIT: begin
				if (state.cnt >= CW'(POR_CYCLES - 1)) begin
					next_state.fsm = SRC_ST_PIN_DRIVE;
					next_state.cnt = '0;
				end
			end
			SRC_ST_PIN_DRIVE: begin
				if (state.cnt >= CW'(SRC_PIN_DRIVE_CYCLES - 1)) begin
					next_state.config_register_two = SRC_CONFIG_RESET;
					next_state.fsm = SRC_ST_INTERNAL_RESET_TAIL;
					next_state.cnt = '0;
				end
			end
			SRC_ST_INTERNAL_RESET_TAIL: begin
				if (state.cnt >= CW'(SRC_INTERNAL_RESET_TAIL_CYCLES - 1)) begin
					next_state.fsm = SRC_ST_RUN;
					next_state.cnt = '0;
					ev[SRC_EV_RESET_DONE] = 1'b1;
				end
			end
			SRC_ST_EXT_HOLD: begin
				if (!pin_low) begin
					next_state.fsm = SRC_ST_INTERNAL_RESET_TAIL;
					next_state.cnt = '0;
				end
			end
			SRC_ST_RUN: begin
				next_state.cnt = '0;
				if (state.control[SRC_CTL_STOP]) begin
					next_state.fsm = SRC_ST_STOP;
					next_state.pre_clear = 1'b1;
				end else if (state.control[SRC_CTL_WAIT]) begin
					next_state.fsm = SRC_ST_WAIT;
				end
			end
			SRC_ST_WAIT: begin
				next_state.cnt = '0;
				if (wake_in || |state.irq_pend) begin
					next_state.fsm = SRC_ST_RUN;
					next_state.control[SRC_CTL_WAIT] = 1'b0;
				end
			end
			SRC_ST_STOP: begin
				next_state.cnt = '0;
				if (wake_in || |state.irq_pend) begin
					next_state.fsm = SRC_ST_STOP_RECOVER;
					next_state.control[SRC_CTL_STOP] = 1'b0;
				end
			end
			SRC_ST_STOP_RECOVER: begin
				if (state.cnt >= (state.config1[SRC_CFG1_SHORT_STOP_RECOVERY] ?
					CW'(SRC_STOP_SHORT_CYCLES - 1) : CW'(STOP_LONG_CYCLES - 1))) begin
					next_state.fsm = SRC_ST_RUN;
					next_state.cnt = '0;
					ev[SRC_EV_STOP_DONE] = 1'b1;
				end
			end
			default: begin
				next_state.fsm = SRC_ST_POR_WAIT;
				next_state.cnt = '0;
			end
		endcase

		// Interrupt request latching.
		if (state.fsm != SRC_ST_POR_WAIT) begin
			next_state.irq_pend = state.irq_pend | irq_req_in;
		end

		// Register writes.
		if (wr_in) begin
			case (addr_in)
				SRC_REG_CONFIG_REGISTER_TWO: next_state.config_register_two = wdata_in;
				SRC_REG_CONFIG1: next_state.config1 = wdata_in;
				SRC_REG_CONTROL: next_state.control = wdata_in;
				SRC_REG_IRQ_STATUS: next_state.irq_status = state.irq_status & ~wdata_in[2:0];
				SRC_REG_IRQ_MASK: next_state.irq_mask = wdata_in[2:0];
				SRC_REG_CAUSE: next_state.irq_pend = (state.fsm != SRC_ST_POR_WAIT) ? irq_req_in : '0;
				default: begin
				end
			endcase
		end

		if (rd_in) begin
			case (addr_in)
				SRC_REG_CAUSE: next_state.rdata = {2'b00, state.cause};
				SRC_REG_CONFIG_REGISTER_TWO: next_state.rdata = state.config_register_two;
				SRC_REG_CONFIG1: next_state.rdata = state.config1;
				SRC_REG_IRQ_STATUS: next_state.rdata = {5'h00, state.irq_status};
				SRC_REG_IRQ_MASK: next_state.rdata = {5'h00, state.irq_mask};
				SRC_REG_CONTROL: next_state.rdata = state.control;
				SRC_REG_IRQ_PEND0: next_state.rdata = state.irq_pend[7:0];
				default: next_state.rdata = 8'h00;
			endcase
			if (addr_in == SRC_REG_CAUSE) begin
				next_state.cause = '0;
			end
		end

		// Pin reset recording, after the minimum low time only.
		if (state.pin_long && state.fsm != SRC_ST_EXT_HOLD) begin
			ev[SRC_EV_PIN_RESET] = 1'b1;
		end
		if (state.pin_long) begin
			next_state.cause[SRC_CAUSE_PIN] = 1'b1;
		end

		// Power-on and low voltage restart the whole sequence; other internal sources restart at the pin drive.
		if (int_src) begin
			next_state.fsm = power_on_pulse_in | low_voltage_in ?
				SRC_ST_POR_WAIT : SRC_ST_PIN_DRIVE;
			next_state.cnt = '0;
			next_state.pre_clear = 1'b1;
			next_state.cause = (power_on_pulse_in ? '0 : state.cause) | src_vec;
			// The pin enable stays until the pin drive ends; power-on clears it at once.
			next_state.config_register_two = power_on_pulse_in ? SRC_CONFIG_RESET : state.config_register_two;
			next_state.config1 = SRC_CONFIG_RESET;
			next_state.control = SRC_CONFIG_RESET;
			next_state.irq_pend = '0;
		end else if (state.pin_long) begin
			next_state.fsm = SRC_ST_EXT_HOLD;
			next_state.control = SRC_CONFIG_RESET;
			next_state.irq_pend = '0;
		end

		next_state.irq_status = next_state.irq_status | ev;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= '0;
			state.fsm <= SRC_ST_POR_WAIT;
			state.pin_meta <= 1'b1;
			state.pin_sync <= 1'b1;
			state.cause <= SRC_CAUSE_W'(1) << SRC_CAUSE_POR;
		end else if (clk_en_in) begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	src_prescaler #(
		.STAGES(SRC_PRESCALE_STAGES)
	) u_prescaler (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.clk_en_in(clk_en_in),
		.clear_in(state.pre_clear),
		.count_out(prescale_out),
		.wdog_tick_out(wdog_tick_out)
	);

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic running;
	assign running = (state.fsm == SRC_ST_RUN) || (state.fsm == SRC_ST_WAIT);

	assign osc_clock_x2_out = state.div[0];
	assign bus_clk_en_out = running && (state.div == 2'd3);
	assign cpu_clk_en_out = (state.fsm == SRC_ST_RUN) && (state.div == 2'd3);
	assign periph_clk_en_out = bus_clk_en_out;
	assign internal_reset_out = ~running;
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_out = (state.fsm == SRC_ST_PIN_DRIVE) && state.config_register_two[SRC_CFG2_RESET_PIN_ENABLE];
	assign reset_pin_pullup_out = state.config_register_two[SRC_CFG2_RESET_PIN_ENABLE];
	assign port_a_bit3_mode_out = ~state.config_register_two[SRC_CFG2_RESET_PIN_ENABLE];
	assign port_a_bit2_mode_out = ~state.config_register_two[SRC_CFG2_IRQEN];
	assign reset_vector_out = state.control[SRC_CTL_MONITOR] ?
		SRC_VEC_MONITOR : SRC_VEC_NORMAL;
	assign irq_pending_out = state.irq_pend;
	assign rdata_out = state.rdata;
	assign irq_out = |(state.irq_status & state.irq_mask);

endmodule // src_reset_clock

// *** src_reset_clock_chk.sv ***
/*
 * Checker for the reset and bus-clock controller port behaviour.
 * Assumes clk_en_in is held high and is bound to every src_reset_clock.
 */
`timescale 1ns/1ps
module src_reset_clock_chk (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic clk_en_in,
	input wire logic power_on_pulse_in,
	input wire logic wdog_timeout_in,
	input wire logic low_voltage_in,
	input wire logic illegal_opcode_in,
	input wire logic illegal_address_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_out,
	input wire logic reset_pin_pullup_out,
	input wire logic port_a_bit3_mode_out,
	input wire logic internal_reset_out,
	input wire logic osc_clock_x2_out,
	input wire logic bus_clk_en_out,
	input wire logic cpu_clk_en_out,
	input wire logic periph_clk_en_out
);
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	logic [7:0] oe_run;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			oe_run <= 8'h00;
		end else begin
			oe_run <= reset_pin_oe_out ? oe_run + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_src;
		clk_en_in && (power_on_pulse_in || wdog_timeout_in || low_voltage_in ||
			illegal_opcode_in || illegal_address_in);
	endsequence
	sequence s_gap;
		!bus_clk_en_out [*3];
	endsequence
	property p_src_internal_reset; s_src |=> internal_reset_out; endproperty
	property p_oe_internal_reset; reset_pin_oe_out |-> internal_reset_out && !reset_pin_out; endproperty
	property p_oe_run; $fell(reset_pin_oe_out) |-> oe_run == 8'h20; endproperty
	property p_bus_gap; bus_clk_en_out |=> s_gap; endproperty
	property p_x2; bus_clk_en_out |=> osc_clock_x2_out != $past(osc_clock_x2_out); endproperty
	property p_cpu; cpu_clk_en_out |-> bus_clk_en_out; endproperty
	property p_periph; periph_clk_en_out == bus_clk_en_out; endproperty
	property p_noclk; internal_reset_out |-> !bus_clk_en_out; endproperty
	property p_mode; port_a_bit3_mode_out == !reset_pin_pullup_out; endproperty
	a_src_internal_reset: assert property (p_src_internal_reset) else $error("source without reset");
	a_oe_internal_reset: assert property (p_oe_internal_reset) else $error("pin drive outside reset");
	a_oe_run: assert property (p_oe_run) else $error("pin drive length");
	a_bus_gap: assert property (p_bus_gap) else $error("bus enable spacing");
	a_x2: assert property (p_x2) else $error("half-rate clock stuck");
	a_cpu: assert property (p_cpu) else $error("cpu enable off phase");
	a_periph: assert property (p_periph) else $error("peripheral enable");
	a_noclk: assert property (p_noclk) else $error("clock during reset");
	a_mode: assert property (p_mode) else $error("pin mode mismatch");
endmodule // src_reset_clock_chk
bind src_reset_clock src_reset_clock_chk u_chk (.clk_in, .rst_n_in, .clk_en_in,
	.power_on_pulse_in, .wdog_timeout_in, .low_voltage_in, .illegal_opcode_in,
	.illegal_address_in, .reset_pin_out, .reset_pin_oe_out, .reset_pin_pullup_out,
	.port_a_bit3_mode_out, .internal_reset_out, .osc_clock_x2_out, .bus_clk_en_out,
	.cpu_clk_en_out, .periph_clk_en_out);

// *** src_pin_model.sv ***
/*
 * Model of the external reset line and the agent that may pull it low.
 * Assumes the bench sets hold_low_in for the wanted number of cycles.
 */
`timescale 1ns/1ps
module src_pin_model (
	input wire logic clk_in,
	input wire logic hold_low_in,
	input wire logic pin_out_in,
	input wire logic oe_in,
	input wire logic pullup_in,
	output logic level_out
);
	// ---------------------------------------------------------------
	// Wire level
	// ---------------------------------------------------------------
	logic last = 1'b0;
	always_ff @(posedge clk_in) begin
		last <= level_out;
	end
	// Pulled high only with the pull-up on; a floating line wanders.
	assign level_out = ((oe_in && !pin_out_in) || hold_low_in) ? 1'b0 :
		(pullup_in ? 1'b1 : !last);
endmodule // src_pin_model

// *** system_reset_clock_control_tb.sv ***
/*
 * Testbench for the reset and bus-clock controller.
 * Assumes the checker is bound and the pin model drives the reset pin.
 */
`timescale 1ns/1ps
module system_reset_clock_control_tb;
	import src_pkg::*;
	logic clk_in = 1'b0, rst_n_in = 1'b0, wdog = 1'b0, lvd = 1'b0, ilop = 1'b0, ilad = 1'b0;
	logic por = 1'b0, wake = 1'b0, wr = 1'b0, rd = 1'b0, hold = 1'b0, pin, oe, pu, pout;
	logic [23:0] irq = 24'h000000;
	logic [23:0] pend;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00, rdata;
	logic internal_reset, bus, cpu, irq_o, mode3, mode2;
	logic [15:0] vec;
	logic [11:0] pre;
	int err_total = 0, comparisons = 0, n, b, c;
	src_reset_clock #(.POR_CYCLES(16), .STOP_LONG_CYCLES(16)) DUT (.clk_in, .rst_n_in,
		.clk_en_in(1'b1), .power_on_pulse_in(por), .wdog_timeout_in(wdog),
		.low_voltage_in(lvd), .illegal_opcode_in(ilop), .illegal_address_in(ilad),
		.reset_pin_in(pin), .irq_req_in(irq), .wake_in(wake), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .reset_pin_out(pout),
		.reset_pin_oe_out(oe), .reset_pin_pullup_out(pu), .port_a_bit3_mode_out(mode3),
		.port_a_bit2_mode_out(mode2), .internal_reset_out(internal_reset), .osc_clock_x2_out(),
		.bus_clk_en_out(bus), .cpu_clk_en_out(cpu), .periph_clk_en_out(),
		.reset_vector_out(vec), .irq_pending_out(pend), .prescale_out(pre),
		.wdog_tick_out(), .irq_out(irq_o));
	src_pin_model u_pin (.clk_in, .hold_low_in(hold), .pin_out_in(pout), .oe_in(oe),
		.pullup_in(pu), .level_out(pin));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task summarize;
		if (err_total == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input string name, input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk_in);
	endtask
	task wrr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	task rdr(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 chk("rdata", rdata, e);
	endtask
	// Counts cycles while reset stays high, from just after the current edge.
	task internal_reset_len;
		n = 0;
		#1;
		while (internal_reset !== 1'b0) begin
			@(posedge clk_in);
			#1 n++;
			if (n > 5000) begin
				err_total++;
				summarize();
			end
		end
	endtask
	task count_en(input int k);
		b = 0;
		c = 0;
		repeat (k) begin
			@(posedge clk_in);
			#1 b += int'(bus === 1'b1);
			c += int'(cpu === 1'b1);
		end
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		cyc(6);
		rst_n_in <= 1'b1;
		internal_reset_len();
		chk("por_len", n, 16 + SRC_PIN_DRIVE_CYCLES + SRC_INTERNAL_RESET_TAIL_CYCLES);
		chk("vector", vec, 16'hfffe);
		chk("modes", {mode3, mode2}, 2'h3);
		rdr(SRC_REG_CAUSE, 8'h01);
		rdr(SRC_REG_CAUSE, 8'h00);
		rdr(SRC_REG_CONFIG_REGISTER_TWO, SRC_CONFIG_RESET);
		rdr(4'hf, 8'h00);
		for (int s = 0; s < 4; s++) begin
			wrr(SRC_REG_CONFIG_REGISTER_TWO, 8'h01);
			@(posedge clk_in);
			{ilad, ilop, lvd, wdog} <= 4'h1 << s;
			@(posedge clk_in);
			{ilad, ilop, lvd, wdog} <= 4'h0;
			internal_reset_len();
			chk("internal_reset_len", n, s == 1 ? 80 : 64);
			rdr(SRC_REG_CAUSE, 8'h01 << (s + 2));
			rdr(SRC_REG_CONFIG_REGISTER_TWO, 8'h00);
		end
		hold <= 1'b1;
		cyc(20);
		hold <= 1'b0;
		#1 chk("pin_ignored", internal_reset, 1'b0);
		wrr(SRC_REG_CONFIG_REGISTER_TWO, 8'h01);
		#1 chk("pin_func", {pu, mode3}, 2'h2);
		hold <= 1'b1;
		cyc(20);
		#1 chk("pin_halt", internal_reset, 1'b1);
		hold <= 1'b0;
		internal_reset_len();
		rdr(SRC_REG_CAUSE, 8'h02);
		wrr(SRC_REG_CONTROL, 8'h02);
		cyc(3);
		count_en(16);
		chk("wait_bus", b, 4);
		chk("wait_cpu", c, 0);
		wake <= 1'b1;
		@(posedge clk_in);
		wake <= 1'b0;
		cyc(8);
		count_en(8);
		chk("wake_cpu", c, 2);
		for (int k = 1; k >= 0; k--) begin
			wrr(SRC_REG_CONFIG1, k ? 8'h01 : 8'h00);
			wrr(SRC_REG_CONTROL, 8'h01);
			count_en(12);
			chk("stop_bus", b, 0);
			wake <= 1'b1;
			@(posedge clk_in);
			wake <= 1'b0;
			n = 0;
			while (bus !== 1'b1 && n < 200) begin
				@(posedge clk_in);
				#1 n++;
			end
			chk("stop_delay", n >= (k ? SRC_STOP_SHORT_CYCLES : 16) &&
				n <= (k ? SRC_STOP_SHORT_CYCLES : 16) + 3, 1);
		end
		wrr(SRC_REG_CONTROL, 8'h04);
		#1 chk("vector_mon", vec, 16'hfefe);
		wrr(SRC_REG_IRQ_STATUS, 8'hff);
		wrr(SRC_REG_IRQ_MASK, 8'h01);
		#1 chk("irq_masked", irq_o, 1'b0);
		@(posedge clk_in);
		irq <= 24'h800020;
		@(posedge clk_in);
		irq <= 24'h000000;
		cyc(2);
		chk("pending", pend, 24'h800020);
		rdr(SRC_REG_IRQ_PEND0, 8'h20);
		wrr(SRC_REG_CONFIG_REGISTER_TWO, 8'h01);
		@(posedge clk_in);
		wdog <= 1'b1;
		@(posedge clk_in);
		wdog <= 1'b0;
		#6 chk("pre_clear", pre, 12'h000);
		internal_reset_len();
		cyc(2);
		chk("irq_raised", irq_o, 1'b1);
		wrr(SRC_REG_IRQ_STATUS, 8'hff);
		cyc(1);
		chk("irq_cleared", irq_o, 1'b0);
		@(posedge clk_in);
		por <= 1'b1;
		@(posedge clk_in);
		por <= 1'b0;
		internal_reset_len();
		chk("por_src_len", n, 16 + SRC_PIN_DRIVE_CYCLES + SRC_INTERNAL_RESET_TAIL_CYCLES);
		rdr(SRC_REG_CAUSE, 8'h01);
		summarize();
	end
endmodule // system_reset_clock_control_tb
